// >>> rtl/pin_mux_pkg.sv
package pin_mux_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W   = 11;
  localparam int AUX_W    = 8;
  localparam int STROBE_N = 4;
  localparam int PMC_W    = 8;
  localparam int CS_W     = 5;
  localparam int CS_LOW_W = 3;
  localparam int PAR_W    = 2;
  localparam int BUS_AW   = 16;
  localparam int BUS_DW   = 32;
  localparam int SEL_W    = 4;

  // ************************************************************
  // pin positions
  // ************************************************************
  localparam int CS_BIT3    = 3;
  localparam int CS_BIT4    = 4;
  localparam int STRAP_LANE = 3;
  localparam int PE_LANE    = 3;
  localparam int MATH_COPROC_FAULT_IRQ_LANE  = 2;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [BUS_AW-1:0] CTRL_ADDR         = 16'h0000;
  localparam logic [BUS_AW-1:0] STATUS_ADDR       = 16'h0004;
  localparam logic [BUS_AW-1:0] PMC_ADDR          = 16'h0008;
  localparam logic [BUS_AW-1:0] PARITY_CTRL_INDEX = 16'h3872;
  localparam logic [BUS_AW-1:0] PARITY_CTRL_ADDR  = PARITY_CTRL_INDEX << 2;

  localparam int CTRL_PD_BIT   = 0;
  localparam int PE_EN_HI_BIT  = 13;
  localparam int PE_EN_LO_BIT  = 12;
  localparam int ST_MODE_BIT   = 0;
  localparam int ST_PE_BIT     = 1;
  localparam int ST_IRQ_BIT    = 2;
  localparam int ST_VALID_BIT  = 3;
  localparam int SEL_LANE0     = 0;
  localparam int SEL_LANE1     = 1;

  localparam logic [1:0] PE_EN_RST    = 2'h0;
  localparam logic       PD_RST       = 1'b0;
  localparam logic       STRAP_RST    = 1'b1;

  // ************************************************************
  // sync lane layout for the single-bit pins
  // ************************************************************
  localparam int SY_STRAP = 0;
  localparam int SY_PE    = 1;
  localparam int SY_MATH_COPROC_FAULT_IRQ  = 2;
  localparam int SY_POWERDOWN_REFRESH_TICK = 3;
  localparam int SY_PMCS  = 4;
  localparam int SY_N     = 5;

endpackage

// >>> rtl/sync_rise.sv
// two-flop synchroniser with a rising-edge pulse per bit
module sync_rise #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic              ready
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [2:0]   fill_r;
  logic [2:0]   fill_nxt;

  always_comb
  begin
    fill_nxt = {fill_r[1:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      fill_r <= '0;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= fill_nxt;
    end
  end

  // no edge is reported until prev_r holds a real pin sample, so a pin
  // already high at reset release gives no false event
  assign q     = sync_r;
  assign ready = fill_r[1];
  assign rise  = fill_r[2] ? (sync_r & ~prev_r) : '0;
endmodule // sync_rise

// >>> rtl/strap_capture.sv
// catches the column-strobe mode strap once, after reset release
module strap_capture
  import pin_mux_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sample_ok,
  input  wire logic strap_level,
  output logic      output_mode,
  output logic      mode_valid
);
  logic mode_r;
  logic mode_nxt;
  logic valid_r;
  logic valid_nxt;

  always_comb
  begin
    mode_nxt  = mode_r;
    valid_nxt = valid_r;
    if (sample_ok && !valid_r)
    begin
      mode_nxt  = strap_level;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r  <= STRAP_RST;
      valid_r <= 1'b0;
    end
    else
    begin
      mode_r  <= mode_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign output_mode = mode_r;
  assign mode_valid  = valid_r;
endmodule // strap_capture

// >>> rtl/dram_pin_mux.sv
// Functional notes
// - DRAM cycles put row then column address on the address pins.
// - I/O cycles put select bits 2..0 on upper address pins.
// - I/O cycles put select bits 3 and 4 on the parity pins.
// - low eight address pins carry a two-way auxiliary byte bus.
// - four row strobes drive DRAM directly.
// - strap pin floats during reset, held high by external pull-up.
// - strap high through reset release latches column-strobe output mode.
// - strap low through reset release latches column-strobe input mode.
// - input mode turns strap and coprocessor pins into inputs.
// - parity-fault pin is released until the mode is known, then an input only in input mode with both enable bits set.
// - parity error is a rising edge of the parity-fault pin.
// - rising edge of coprocessor pin in input mode raises IRQ13.
// - write_not_read is high for writes, low for reads.
// - in power down the refresh tick passes to refresh request.
// - sample strobe captures the eight power-management inputs.
module dram_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [pin_mux_pkg::BUS_AW-1:0] adr_i,
  input  wire logic [pin_mux_pkg::SEL_W-1:0]  sel_i,
  input  wire logic [pin_mux_pkg::BUS_DW-1:0] dat_i,
  output logic      [pin_mux_pkg::BUS_DW-1:0] dat_o,
  output logic                                ack_o,
  input  wire logic                           dram_cycle,
  input  wire logic                           io_cycle,
  input  wire logic                           column_phase,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] row_address,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] column_address,
  input  wire logic                           mem_write,
  input  wire logic [pin_mux_pkg::STROBE_N-1:0] ras_select,
  input  wire logic [pin_mux_pkg::STROBE_N-1:0] cas_high_select,
  input  wire logic [pin_mux_pkg::STROBE_N-1:0] cas_low_select,
  input  wire logic [pin_mux_pkg::PAR_W-1:0]  parity_write,
  output logic      [pin_mux_pkg::PAR_W-1:0]  parity_read,
  input  wire logic [pin_mux_pkg::CS_W-1:0]   io_select_code,
  input  wire logic [pin_mux_pkg::AUX_W-1:0]  aux_write_data,
  input  wire logic                           aux_write,
  output logic      [pin_mux_pkg::AUX_W-1:0]  aux_read_data,
  input  wire logic                           core_refresh_req,
  output logic      [pin_mux_pkg::ADDR_W-1:0] dram_row_col_address_o,
  output logic                                dram_row_col_address_low_oe,
  input  wire logic [pin_mux_pkg::AUX_W-1:0]  aux_byte_bus_lines_i,
  output logic      [pin_mux_pkg::PAR_W-1:0]  parity_pins_o,
  output logic                                parity_pins_oe,
  input  wire logic [pin_mux_pkg::PAR_W-1:0]  parity_pins_i,
  output logic      [pin_mux_pkg::STROBE_N-1:0] row_strobe_lines_b,
  output logic      [pin_mux_pkg::STROBE_N-1:0] column_strobe_high_lines_b,
  output logic                                column_strobe_mode_strap_oe,
  input  wire logic                           column_strobe_mode_strap_i,
  output logic      [pin_mux_pkg::STROBE_N-1:0] column_strobe_low_lines_b,
  output logic                                parity_fault_input_oe,
  input  wire logic                           parity_fault_input_i,
  output logic                                math_coproc_fault_irq_oe,
  input  wire logic                           math_coproc_fault_irq_i,
  output logic                                write_not_read,
  input  wire logic                           powerdown_refresh_tick,
  output logic                                refresh_request,
  input  wire logic                           power_mgmt_sample_strobe,
  input  wire logic [pin_mux_pkg::PMC_W-1:0]  power_mgmt_inputs,
  output logic      [pin_mux_pkg::PMC_W-1:0]  power_mgmt_latched,
  output logic                                irq13_request,
  output logic                                parity_error_pulse
);
  import pin_mux_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic       rst_pipe_r;
  logic       rst_sync_b;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_pipe_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_pipe_r <= 1'b1;
      rst_sync_b <= rst_pipe_r;
    end
  end

  // ************************************************************
  // pin synchronisers and strap
  // ************************************************************
  localparam int DW = PMC_W + AUX_W + PAR_W;
  logic [SY_N-1:0] sy_q;
  logic [SY_N-1:0] sy_rise;
  logic            sy_ready;
  logic [DW-1:0]   dq;
  logic            output_mode;
  logic            mode_valid;
  logic            input_mode;

  sync_rise #(.W(SY_N)) u_sync_ctl (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .d     ({power_mgmt_sample_strobe, powerdown_refresh_tick,
             math_coproc_fault_irq_i, parity_fault_input_i,
             column_strobe_mode_strap_i}),
    .q     (sy_q),
    .rise  (sy_rise),
    .ready (sy_ready)
  );

  // bus data lanes are synchronised too, so they arrive two clocks late
  sync_rise #(.W(DW)) u_sync_data (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .d     ({power_mgmt_inputs, aux_byte_bus_lines_i, parity_pins_i}),
    .q     (dq),
    .rise  (),
    .ready ()
  );

  strap_capture u_strap (
    .clk         (clk),
    .rst_b       (rst_sync_b),
    .sample_ok   (sy_ready),
    .strap_level (sy_q[SY_STRAP]),
    .output_mode (output_mode),
    .mode_valid  (mode_valid)
  );

  assign input_mode = mode_valid && !output_mode;

  // ************************************************************
  // register state
  // ************************************************************
  logic             ack_r, ack_nxt;
  logic [BUS_DW-1:0] rdat_r, rdat_nxt;
  logic             pd_r, pd_nxt;
  logic [1:0]       pe_en_r, pe_en_nxt;
  logic             st_pe_r, st_pe_nxt;
  logic             st_irq_r, st_irq_nxt;
  logic [PMC_W-1:0] pmc_r, pmc_nxt;
  logic             req;
  logic             wr_ok;
  logic             pe_as_input;
  logic             pe_event;
  logic             irq_event;

  assign req         = cyc_i && stb_i && !ack_r;
  assign wr_ok       = cyc_i && stb_i && we_i && ack_r;
  assign pe_as_input = input_mode && (pe_en_r == 2'h3);
  assign pe_event    = pe_as_input && sy_rise[SY_PE];
  assign irq_event   = input_mode && sy_rise[SY_MATH_COPROC_FAULT_IRQ];

  always_comb
  begin
    ack_nxt    = req;
    rdat_nxt   = rdat_r;
    pd_nxt     = pd_r;
    pe_en_nxt  = pe_en_r;
    st_pe_nxt  = st_pe_r;
    st_irq_nxt = st_irq_r;
    pmc_nxt    = pmc_r;
    if (req)
    begin
      rdat_nxt = '0;
      case (adr_i)
        CTRL_ADDR:        rdat_nxt[CTRL_PD_BIT] = pd_r;
        PARITY_CTRL_ADDR: rdat_nxt[PE_EN_HI_BIT:PE_EN_LO_BIT] = pe_en_r;
        STATUS_ADDR:
        begin
          rdat_nxt[ST_MODE_BIT]  = input_mode;
          rdat_nxt[ST_PE_BIT]    = st_pe_r;
          rdat_nxt[ST_IRQ_BIT]   = st_irq_r;
          rdat_nxt[ST_VALID_BIT] = mode_valid;
        end
        PMC_ADDR:         rdat_nxt[PMC_W-1:0] = pmc_r;
        default:          rdat_nxt = '0;
      endcase
    end
    // writes land on the edge that the master sees ack
    if (wr_ok)
    begin
      case (adr_i)
        CTRL_ADDR:
          if (sel_i[SEL_LANE0])
            pd_nxt = dat_i[CTRL_PD_BIT];
        PARITY_CTRL_ADDR:
          if (sel_i[SEL_LANE1])
            pe_en_nxt = dat_i[PE_EN_HI_BIT:PE_EN_LO_BIT];
        STATUS_ADDR:
          if (sel_i[SEL_LANE0])
          begin
            st_pe_nxt  = st_pe_r && !dat_i[ST_PE_BIT];
            st_irq_nxt = st_irq_r && !dat_i[ST_IRQ_BIT];
          end
        default:
          pd_nxt = pd_r;
      endcase
    end
    // a new event outranks a clear in the same cycle
    if (pe_event)
      st_pe_nxt = 1'b1;
    if (irq_event)
      st_irq_nxt = 1'b1;
    if (sy_rise[SY_PMCS])
      pmc_nxt = dq[DW-1 -: PMC_W];
  end

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ack_r    <= 1'b0;
      rdat_r   <= '0;
      pd_r     <= PD_RST;
      pe_en_r  <= PE_EN_RST;
      st_pe_r  <= 1'b0;
      st_irq_r <= 1'b0;
      pmc_r    <= '0;
    end
    else
    begin
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      pd_r     <= pd_nxt;
      pe_en_r  <= pe_en_nxt;
      st_pe_r  <= st_pe_nxt;
      st_irq_r <= st_irq_nxt;
      pmc_r    <= pmc_nxt;
    end
  end

  assign ack_o              = ack_r;
  assign dat_o              = rdat_r;
  assign power_mgmt_latched = pmc_r;

  // ************************************************************
  // pin drive
  // ************************************************************
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic                low_oe_r, low_oe_nxt;
  logic [PAR_W-1:0]    par_r, par_nxt;
  logic                par_oe_r, par_oe_nxt;
  logic [STROBE_N-1:0] ras_r, ras_nxt;
  logic [STROBE_N-1:0] cash_r, cash_nxt;
  logic [STROBE_N-1:0] casl_r, casl_nxt;
  logic                wnr_r, wnr_nxt;
  logic                ref_r, ref_nxt;
  logic                irq_r, pe_r;
  logic [AUX_W-1:0]    aux_r, aux_nxt;
  logic [PAR_W-1:0]    pin_r, pin_nxt;

  always_comb
  begin
    addr_nxt   = addr_r;
    low_oe_nxt = 1'b1;
    par_nxt    = par_r;
    par_oe_nxt = 1'b0;
    wnr_nxt    = wnr_r;
    aux_nxt    = aux_r;
    pin_nxt    = pin_r;
    if (io_cycle)
    begin
      addr_nxt[ADDR_W-1 -: CS_LOW_W] = io_select_code[CS_LOW_W-1:0];
      addr_nxt[AUX_W-1:0] = aux_write_data;
      low_oe_nxt          = aux_write;
      par_nxt             = {io_select_code[CS_BIT4],
                             io_select_code[CS_BIT3]};
      par_oe_nxt          = 1'b1;
      if (!aux_write)
        aux_nxt = dq[PAR_W +: AUX_W];
    end
    else if (dram_cycle)
    begin
      addr_nxt   = column_phase ? column_address : row_address;
      par_nxt    = parity_write;
      par_oe_nxt = mem_write;
      wnr_nxt    = mem_write;
      if (!mem_write)
        pin_nxt = dq[PAR_W-1:0];
    end
    // strobes are active low and only fire inside a DRAM cycle
    ras_nxt  = ~(ras_select & {STROBE_N{dram_cycle && !io_cycle}});
    cash_nxt = ~(cas_high_select &
                 {STROBE_N{dram_cycle && !io_cycle && column_phase}});
    casl_nxt = ~(cas_low_select &
                 {STROBE_N{dram_cycle && !io_cycle && column_phase}});
    // the tick is a raw pin, so it goes through its synchroniser first
    ref_nxt  = pd_r ? sy_q[SY_POWERDOWN_REFRESH_TICK] : core_refresh_req;
  end

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      addr_r   <= '0;
      low_oe_r <= 1'b0;
      par_r    <= '0;
      par_oe_r <= 1'b0;
      ras_r    <= '1;
      cash_r   <= '1;
      casl_r   <= '1;
      wnr_r    <= 1'b0;
      ref_r    <= 1'b0;
      irq_r    <= 1'b0;
      pe_r     <= 1'b0;
      aux_r    <= '0;
      pin_r    <= '0;
    end
    else
    begin
      addr_r   <= addr_nxt;
      low_oe_r <= low_oe_nxt;
      par_r    <= par_nxt;
      par_oe_r <= par_oe_nxt;
      ras_r    <= ras_nxt;
      cash_r   <= cash_nxt;
      casl_r   <= casl_nxt;
      wnr_r    <= wnr_nxt;
      ref_r    <= ref_nxt;
      irq_r    <= irq_event;
      pe_r     <= pe_event;
      aux_r    <= aux_nxt;
      pin_r    <= pin_nxt;
    end
  end

  assign dram_row_col_address_o      = addr_r;
  assign dram_row_col_address_low_oe = low_oe_r;
  assign parity_pins_o               = par_r;
  assign parity_pins_oe              = par_oe_r;
  assign row_strobe_lines_b          = ras_r;
  assign column_strobe_high_lines_b  = cash_r;
  assign column_strobe_low_lines_b   = casl_r;
  assign write_not_read              = wnr_r;
  assign refresh_request             = ref_r;
  assign irq13_request               = irq_r;
  assign parity_error_pulse          = pe_r;
  assign aux_read_data               = aux_r;
  assign parity_read                 = pin_r;
  // strap pin stays released until the mode is known; pull-up is external
  assign column_strobe_mode_strap_oe = mode_valid && output_mode;
  assign math_coproc_fault_irq_oe    = mode_valid && output_mode;
  assign parity_fault_input_oe       = mode_valid && !pe_as_input;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  column_addr_a: assert property (dram_cycle && !io_cycle && column_phase |=>
    dram_row_col_address_o == $past(column_address))
    else $error("column address not driven");
  io_select_a: assert property (io_cycle |=>
    dram_row_col_address_o[ADDR_W-1 -: CS_LOW_W] == $past(io_select_code[CS_LOW_W-1:0]))
    else $error("select bits not on upper address");
  io_parity_a: assert property (io_cycle |=> parity_pins_oe &&
    parity_pins_o == $past({io_select_code[CS_BIT4], io_select_code[CS_BIT3]}))
    else $error("select bits 3 and 4 not on parity pins");
  aux_turn_a: assert property (io_cycle && !aux_write |=> !dram_row_col_address_low_oe)
    else $error("aux bus driven during read");
  row_strobe_a: assert property (dram_cycle && !io_cycle |=>
    row_strobe_lines_b == ~$past(ras_select))
    else $error("row strobes wrong");
  strap_float_a: assert property (!mode_valid |-> !column_strobe_mode_strap_oe)
    else $error("strap driven before mode latched");
  mode_out_a: assert property (mode_valid && output_mode |->
    column_strobe_mode_strap_oe && math_coproc_fault_irq_oe && parity_fault_input_oe)
    else $error("output mode pins not driven");
  mode_in_a: assert property ($rose(mode_valid) && !output_mode |->
    (!column_strobe_mode_strap_oe && !math_coproc_fault_irq_oe) [*3])
    else $error("input mode pins driven");
  pe_gate_a: assert property (mode_valid |->
    parity_fault_input_oe == !(input_mode && pe_en_r == 2'h3))
    else $error("parity fault pin direction wrong");
  pe_edge_a: assert property (pe_as_input && sy_rise[SY_PE] |=> parity_error_pulse ##1
    !parity_error_pulse)
    else $error("parity error edge lost or repeated");
  irq_edge_a: assert property (irq13_request |-> $past(input_mode) &&
    $past(sy_q[SY_MATH_COPROC_FAULT_IRQ]) && !$past(sy_q[SY_MATH_COPROC_FAULT_IRQ], 2))
    else $error("irq13 without rising edge");
  wnr_a: assert property (dram_cycle && !io_cycle |=> write_not_read == $past(mem_write))
    else $error("write_not_read wrong");
  refresh_a: assert property (pd_r |=> refresh_request == $past(sy_q[SY_POWERDOWN_REFRESH_TICK]))
    else $error("refresh tick not passed");
  pmc_a: assert property (sy_rise[SY_PMCS] |=>
    power_mgmt_latched == $past(dq[DW-1 -: PMC_W]))
    else $error("pmc inputs not captured");
  one_event_a: assert property (irq13_request |=> !irq13_request)
    else $error("irq13 longer than one cycle");

  input_mode_c: cover property ($rose(mode_valid) && !output_mode);
  parity_err_c: cover property (parity_error_pulse);
  io_read_c:    cover property (io_cycle && !aux_write ##1 io_cycle);
  pd_refresh_c: cover property (pd_r && refresh_request);

endmodule // dram_pin_mux

// >>> test/far_side_model.sv
// chip-select decoder and byte peripheral on the shared address pins
module far_side_model
  import pin_mux_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] addr,
  input  wire logic                           low_oe,
  input  wire logic [pin_mux_pkg::PAR_W-1:0]  par,
  input  wire logic                           par_oe,
  output logic      [pin_mux_pkg::AUX_W-1:0]  aux
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [AUX_W-1:0] aux_nxt;
  // selected device answers with its five-bit select code
  // a released bus flips each cycle so a stale byte never reads as good
  always_comb aux_nxt = (par_oe && !low_oe) ? {3'h5, par, addr[10:8]} : ~aux;
  initial aux = 8'h00;
  always @(posedge clk) aux <= aux_nxt;
endmodule // far_side_model

// >>> test/dram_pin_mux_and_strobe_strap_tb_top.sv
module dram_pin_mux_and_strobe_strap_tb_top;
  import pin_mux_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, cyc_i, stb_i, we_i, dram_cycle, io_cycle, column_phase, mem_write;
  logic aux_write, core_refresh_req, powerdown_refresh_tick, power_mgmt_sample_strobe;
  logic ack_o, write_not_read, dram_row_col_address_low_oe, parity_pins_oe, refresh_request;
  logic column_strobe_mode_strap_oe, parity_fault_input_oe, math_coproc_fault_irq_oe;
  logic irq13_request, parity_error_pulse, column_strobe_mode_strap_i, parity_fault_input_i;
  logic math_coproc_fault_irq_i, strap_low, pe_drv, math_coproc_fault_irq_drv;
  logic [BUS_AW-1:0]   adr_i;
  logic [SEL_W-1:0]    sel_i;
  logic [BUS_DW-1:0]   dat_i, dat_o;
  logic [ADDR_W-1:0]   row_address, column_address, dram_row_col_address_o, r, c;
  logic [STROBE_N-1:0] ras_select, cas_high_select, cas_low_select, row_strobe_lines_b;
  logic [STROBE_N-1:0] column_strobe_high_lines_b, column_strobe_low_lines_b;
  logic [PAR_W-1:0]    parity_write, parity_read, parity_pins_o, parity_pins_i;
  logic [CS_W-1:0]     io_select_code, cs;
  logic [AUX_W-1:0]    aux_write_data, aux_read_data, aux_byte_bus_lines_i, far_aux, b;
  logic [PMC_W-1:0]    power_mgmt_inputs, power_mgmt_latched;
  logic [BUS_DW-1:0]   expq[$];
  int                  miscompares, n_tests, k;
  // ************************************************************
  // pin resolution
  // ************************************************************
  assign aux_byte_bus_lines_i = dram_row_col_address_low_oe ? dram_row_col_address_o[7:0] : far_aux;
  assign parity_pins_i = parity_pins_oe ? parity_pins_o : ~parity_pins_o;
  // pull-up, or the pull-down that reset switches
  assign column_strobe_mode_strap_i = column_strobe_mode_strap_oe ? column_strobe_high_lines_b[3]
                                                                  : !strap_low;
  assign parity_fault_input_i = parity_fault_input_oe ? column_strobe_low_lines_b[3] : pe_drv;
  assign math_coproc_fault_irq_i = math_coproc_fault_irq_oe ? column_strobe_low_lines_b[2]
                                                            : math_coproc_fault_irq_drv;
  dram_pin_mux dut_u (.*);
  far_side_model far_u (.clk(clk), .addr(dram_row_col_address_o),
    .low_oe(dram_row_col_address_low_oe), .par(parity_pins_o), .par_oe(parity_pins_oe),
    .aux(far_aux));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // no fixed latency assumed: wait for ack under a bound
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
    if (!w) expq.push_back(e);
    @(posedge clk);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
    repeat (20) if (ack_o !== 1'b1) @(posedge clk);
    if (ack_o !== 1'b1)
    begin
      miscompares++;
      close_out;
    end
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task rst(input logic lo);
    rst_b <= 1'b0;
    strap_low <= lo;
    step(5);
    rst_b <= 1'b1;
    step(14);
  endtask
  // a held-high level must give exactly one event
  task cnt(input logic pe);
    k = 0;
    if (pe) pe_drv <= 1'b1;
    else math_coproc_fault_irq_drv <= 1'b1;
    repeat (10)
    begin
      @(posedge clk);
      k += pe ? (parity_error_pulse === 1'b1) : (irq13_request === 1'b1);
    end
    {pe_drv, math_coproc_fault_irq_drv} <= 2'b00;
  endtask
  always @(posedge clk)
    if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
      chk(dat_o, expq.pop_front(), "read data");
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {cyc_i, stb_i, we_i, dram_cycle, io_cycle, column_phase, mem_write, aux_write, rst_b,
     core_refresh_req, powerdown_refresh_tick, power_mgmt_sample_strobe, strap_low, pe_drv,
     math_coproc_fault_irq_drv, adr_i, sel_i, dat_i, row_address, column_address, ras_select, cas_high_select,
     cas_low_select, parity_write, io_select_code, aux_write_data, power_mgmt_inputs} = '0;
    {miscompares, n_tests} = '0;
    void'($urandom(32'h621f));
    rst(1'b0);
    wb(1'b0, STATUS_ADDR, 32'h0, 32'h8);
    chk(column_strobe_mode_strap_oe, 1'b1, "strap oe");
    r = $urandom;
    c = $urandom;
    {dram_cycle, row_address, column_address, ras_select, mem_write} <= {1'b1, r, c, 4'h1, 1'b1};
    step(2);
    chk(dram_row_col_address_o, r, "row");
    chk(row_strobe_lines_b, 4'he, "ras");
    chk(write_not_read, 1'b1, "wnr");
    {column_phase, cas_high_select, cas_low_select, mem_write} <= {1'b1, 4'h8, 4'h4, 1'b0};
    step(2);
    chk(dram_row_col_address_o, c, "column");
    chk({column_strobe_high_lines_b, column_strobe_low_lines_b}, 8'h7b, "cas");
    chk(write_not_read, 1'b0, "wnr");
    step(3);
    chk(parity_read, 2'h3, "parity read");
    $display("test dram done");
    cs = $urandom;
    b = $urandom;
    {io_cycle, io_select_code, aux_write, aux_write_data} <= {1'b1, cs, 1'b1, b};
    step(2);
    chk(dram_row_col_address_o, {cs[2:0], b}, "io addr");
    chk({parity_pins_oe, parity_pins_o}, {1'b1, cs[4], cs[3]}, "cs43");
    chk({dram_row_col_address_low_oe, row_strobe_lines_b}, 5'h1f, "io strobes");
    aux_write <= 1'b0;
    step(7);
    chk(dram_row_col_address_low_oe, 1'b0, "aux oe");
    chk(aux_read_data, {3'h5, cs}, "aux read");
    {io_cycle, dram_cycle, ras_select, cas_high_select, cas_low_select, core_refresh_req} <= 15'h1;
    $display("test io done");
    step(4);
    chk(refresh_request, 1'b1, "refresh");
    wb(1'b1, CTRL_ADDR, 32'h1, 32'h0);
    step(4);
    chk(refresh_request, 1'b0, "pd refresh");
    powerdown_refresh_tick <= 1'b1;
    step(5);
    chk(refresh_request, 1'b1, "pd tick");
    wb(1'b1, CTRL_ADDR, 32'h0, 32'h0);
    b = $urandom;
    {power_mgmt_inputs, power_mgmt_sample_strobe} <= {b, 1'b1};
    step(4);
    power_mgmt_sample_strobe <= 1'b0;
    step(6);
    power_mgmt_inputs <= ~b;
    wb(1'b0, PMC_ADDR, 32'h0, {24'h0, b});
    wb(1'b0, 16'h0100, 32'h0, 32'h0);
    $display("test power done");
    rst(1'b1);
    wb(1'b0, STATUS_ADDR, 32'h0, 32'h9);
    chk({column_strobe_mode_strap_oe, math_coproc_fault_irq_oe}, 2'h0, "in oe");
    chk(parity_fault_input_oe, 1'b1, "pe oe");
    wb(1'b1, PARITY_CTRL_ADDR, 32'h3000, 32'h0);
    wb(1'b0, PARITY_CTRL_ADDR, 32'h0, 32'h3000);
    step(2);
    chk(parity_fault_input_oe, 1'b0, "pe oe set");
    cnt(1'b1);
    chk(k, 1, "parity events");
    cnt(1'b0);
    chk(k, 1, "irq13 events");
    wb(1'b0, STATUS_ADDR, 32'h0, 32'hf);
    wb(1'b1, STATUS_ADDR, 32'h6, 32'h0);
    wb(1'b0, STATUS_ADDR, 32'h0, 32'h9);
    step(2);
    $display("test input mode done");
    close_out;
  end
endmodule // dram_pin_mux_and_strobe_strap_tb_top
